//--- rtl/fan_pkg.sv
// Shared constants and types for the two-coil fan commutation block.
// Assumes a 100 MHz clock and a 1 us timing tick derived from it.
package fan_pkg;

  // Clock and timing tick
  localparam int CLK_HZ = 100_000_000;
  localparam int CLK_PERIOD_NS = 10;
  localparam int TICK_NS = 1000;
  localparam int TICK_CYC = TICK_NS / CLK_PERIOD_NS;
  localparam int DIV_W = 7;

  // Protection times, figures in their own units
  localparam int LOCK_TIME_MS = 430;
  localparam int RESTART_TIME_MS = 3000;
  localparam int POR_HOLD_US = 500;
  localparam int ALARM_FREQ_MHZ = 1150;
  localparam int TIMER_W = 24;

  // Same times as counts of 1 us ticks
  localparam logic [23:0] LOCK_US = 24'(LOCK_TIME_MS * 1000);
  localparam logic [23:0] RESTART_US = 24'(RESTART_TIME_MS * 1000);
  localparam logic [23:0] POR_US = 24'(POR_HOLD_US);
  localparam logic [23:0] ALARM_US = 24'(1_000_000_000 / ALARM_FREQ_MHZ);

  // Adaptive speed window, two pole pairs give four pole changes a turn
  localparam int POLES_PER_REV = 4;
  localparam int RPM_MIN = 2300;
  localparam int RPM_MAX = 6700;
  localparam logic [23:0] HALF_MIN_US = 24'(60_000_000 / (RPM_MAX * POLES_PER_REV));
  localparam logic [23:0] HALF_MAX_US = 24'(60_000_000 / (RPM_MIN * POLES_PER_REV));

  // Target ratio 6.25 percent, slope time times 16 against half period
  localparam int RATIO_PCT_X100 = 625;
  localparam int RATIO_DIV = 10000 / RATIO_PCT_X100;

  // Slope code
  localparam int SLOPE_W = 8;
  localparam int MEAS_W = 16;
  localparam logic [7:0] SLOPE_MIN = 8'h01;
  localparam logic [7:0] SLOPE_MAX = 8'hFF;
  localparam logic [7:0] SLOPE_RST = 8'h20;
  localparam logic [15:0] MEAS_MAX = 16'hFFFF;

  // Register map, byte addresses
  localparam int ADDR_W = 8;
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_SLOPE = 8'h04;
  localparam logic [7:0] REG_STATUS = 8'h08;
  localparam logic [7:0] REG_HALF = 8'h0C;
  localparam logic [7:0] REG_MEAS = 8'h10;

  // Control fields and reset values
  localparam int CTRL_ALARM_BIT = 0;
  localparam int CTRL_ADAPT_BIT = 1;
  localparam logic CTRL_ALARM_RST = 1'b0;
  localparam logic CTRL_ADAPT_RST = 1'b1;

  // Status fields
  localparam int ST_POLE_BIT = 0;
  localparam int ST_HOT1_BIT = 1;
  localparam int ST_HOT2_BIT = 2;
  localparam int ST_SLOW_BIT = 3;
  localparam int ST_STATE_LSB = 4;
  localparam int ST_POR_BIT = 6;

  // Bus responses
  localparam logic [1:0] RESP_OKAY = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;

  // Locked-rotor protection states
  typedef enum logic [1:0] {
    LK_RUN = 2'b00,
    LK_OFF = 2'b01,
    LK_RETRY = 2'b10
  } lock_state_t;

endpackage

//--- rtl/fan_commute_top.sv
// Commutation, locked-rotor, slope adaptation and thermal logic of a
// two-coil fan driver, with an AXI4-Lite register slave.
// Assumes analog comparators for pole and thermal flags and an analog
// slope shaper that takes slope_setting and drives the coil pins.
//
// Behaviour
// - South pole pulls coil A low, releases B, speed pin low; north the reverse.
// - Speed-pulse variant: speed pin follows the latched pole.
// - Alarm variant: pin driven low while the motor spins normally.
// - Alarm variant: pin released when pole changes fall below about 1.15 Hz.
// - No pole change for 0.43 s means blocked rotor: both coils off.
// - While blocked, re-energise coils about every 3 s until rotation resumes.
// - Coil drives always complementary while running.
// - In locked-rotor protection the speed pin is forced high.
// - Speed is measured as time between successive pole changes.
// - Slope time runs from coil A falling start to its crossover.
// - Ratio is twice slope time over full output period.
// - Ratio below 6.25 percent lengthens the slope setting.
// - Ratio above 6.25 percent shortens the slope setting.
// - Slope code steps up or down, applied before next rising slope of A.
// - Slopes start at threshold crossings, not from field amplitude.
// - Adaptation holds the ratio between 2300 and 6700 RPM.
// - First thermal flag halves the slope in use, fan keeps running.
// - Full slope returns only when the first thermal flag clears.
// - Second thermal flag shuts down, releasing all outputs high.
// - Outputs stay high until the second thermal flag clears.
// - After reset the speed or alarm pin is held high for 500 us.
`timescale 1ns/1ps

module fan_commute_top #(
  parameter logic [23:0] LOCK_US = fan_pkg::LOCK_US,
  parameter logic [23:0] RESTART_US = fan_pkg::RESTART_US,
  parameter logic [23:0] POR_US = fan_pkg::POR_US,
  parameter logic [23:0] ALARM_US = fan_pkg::ALARM_US
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Comparator flags from the analog front end
  input wire logic pole_south_in,
  input wire logic thermal_stage1_in,
  input wire logic thermal_stage2_in,
  // Coil A open-drain pin
  input wire logic coil_drive_a_in,
  output logic coil_drive_a_out,
  output logic coil_drive_a_oe_n,
  // Coil B open-drain pin
  input wire logic coil_drive_b_in,
  output logic coil_drive_b_out,
  output logic coil_drive_b_oe_n,
  // Speed pulse or alarm open-drain pin
  input wire logic speed_pulse_in,
  output logic speed_pulse_out,
  output logic speed_pulse_oe_n,
  // Slope code to the analog slope shaper
  output logic [fan_pkg::SLOPE_W-1:0] slope_setting,
  // AXI4-Lite write address
  input wire logic [fan_pkg::ADDR_W-1:0] s_axi_awaddr,
  input wire logic [2:0] s_axi_awprot,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  // AXI4-Lite write data
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  // AXI4-Lite write response
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  // AXI4-Lite read address
  input wire logic [fan_pkg::ADDR_W-1:0] s_axi_araddr,
  input wire logic [2:0] s_axi_arprot,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  // AXI4-Lite read data
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready
);
  import fan_pkg::*;

  localparam logic [23:0] OFF_US = RESTART_US - LOCK_US;

  // Saturating step of the slope code
  function automatic logic [7:0] step_code(input logic [7:0] code,
                                           input logic up, input logic down);
    logic [7:0] res;
    res = code;
    if (up && code != SLOPE_MAX) begin
      res = code + 8'h01;
    end else if (down && code != SLOPE_MIN) begin
      res = code - 8'h01;
    end
    return res;
  endfunction

  // Word-aligned register address
  function automatic logic [7:0] word_addr(input logic [7:0] a);
    return {a[7:2], 2'b00};
  endfunction

  logic [DIV_W-1:0] div_ff;
  logic tick_ff;
  logic [3:0] meta_ff;
  logic [3:0] sync_ff;
  logic pole_s;
  logic hot1_s;
  logic hot2_s;
  logic a_low_s;
  logic pole_ff;
  logic pole_chg;
  logic [23:0] half_cnt_ff;
  logic [23:0] last_half_ff;
  logic slow;
  lock_state_t state_ff;
  logic [23:0] lk_timer_ff;
  logic [23:0] por_cnt_ff;
  logic por_done_ff;
  logic meas_on_ff;
  logic [MEAS_W-1:0] meas_cnt_ff;
  logic [MEAS_W-1:0] last_meas_ff;
  logic meas_done;
  logic [23:0] meas_scaled;
  logic in_window;
  logic [7:0] code_ff;
  logic alarm_mode_ff;
  logic adapt_en_ff;
  logic energize;
  logic [7:0] aw_addr_ff;
  logic aw_full_ff;
  logic [31:0] w_data_ff;
  logic [3:0] w_strb_ff;
  logic w_full_ff;
  logic wr_en;
  logic wr_hit;
  logic [31:0] rd_word;
  logic rd_hit;

  // 1 us tick so long timers stay within 24 bits
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      div_ff <= '0;
      tick_ff <= 1'b0;
    end else if (div_ff == DIV_W'(TICK_CYC - 1)) begin
      div_ff <= '0;
      tick_ff <= 1'b1;
    end else begin
      div_ff <= div_ff + 7'h01;
      tick_ff <= 1'b0;
    end
  end

  // Two-stage synchronisers on comparator results and pin readback
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meta_ff <= 4'h0;
      sync_ff <= 4'h0;
    end else begin
      meta_ff <= {~coil_drive_a_in, thermal_stage2_in, thermal_stage1_in,
                  pole_south_in};
      sync_ff <= meta_ff;
    end
  end

  assign pole_s = sync_ff[0];
  assign hot1_s = sync_ff[1];
  assign hot2_s = sync_ff[2];
  assign a_low_s = sync_ff[3];

  // Pole change seen only at the comparator threshold crossing
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pole_ff <= 1'b0;
    end else begin
      pole_ff <= pole_s;
    end
  end

  assign pole_chg = pole_s != pole_ff;

  // Time between pole changes, saturating
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      half_cnt_ff <= 24'h0;
      last_half_ff <= 24'h0;
    end else if (pole_chg) begin
      half_cnt_ff <= 24'h0;
      last_half_ff <= half_cnt_ff;
    end else if (tick_ff && half_cnt_ff != 24'hFFFFFF) begin
      half_cnt_ff <= half_cnt_ff + 24'h000001;
    end
  end

  assign slow = half_cnt_ff >= ALARM_US;

  // Locked-rotor protection: off after stall, periodic retry
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      state_ff <= LK_RUN;
      lk_timer_ff <= 24'h0;
    end else begin
      unique case (state_ff)
        LK_RUN: begin
          lk_timer_ff <= 24'h0;
          if (!pole_chg && half_cnt_ff >= LOCK_US) begin
            state_ff <= LK_OFF;
          end
        end
        LK_OFF: begin
          if (pole_chg) begin
            state_ff <= LK_RUN;
            lk_timer_ff <= 24'h0;
          end else if (tick_ff) begin
            if (lk_timer_ff >= OFF_US - 24'h000001) begin
              state_ff <= LK_RETRY;
              lk_timer_ff <= 24'h0;
            end else begin
              lk_timer_ff <= lk_timer_ff + 24'h000001;
            end
          end
        end
        LK_RETRY: begin
          if (pole_chg) begin
            state_ff <= LK_RUN;
            lk_timer_ff <= 24'h0;
          end else if (tick_ff) begin
            if (lk_timer_ff >= LOCK_US - 24'h000001) begin
              state_ff <= LK_OFF;
              lk_timer_ff <= 24'h0;
            end else begin
              lk_timer_ff <= lk_timer_ff + 24'h000001;
            end
          end
        end
        default: begin
          state_ff <= LK_RUN;
          lk_timer_ff <= 24'h0;
        end
      endcase
    end
  end

  // Power-on hold of the speed or alarm pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      por_cnt_ff <= 24'h0;
      por_done_ff <= 1'b0;
    end else if (!por_done_ff && tick_ff) begin
      por_cnt_ff <= por_cnt_ff + 24'h000001;
      if (por_cnt_ff >= POR_US - 24'h000001) begin
        por_done_ff <= 1'b1;
      end
    end
  end

  // Coils are driven only in run or retry and never while overheated
  assign energize = (state_ff != LK_OFF) && !hot2_s;

  // Slope time: from coil A pull-down start to its crossover
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      meas_on_ff <= 1'b0;
      meas_cnt_ff <= '0;
      last_meas_ff <= '0;
    end else if (pole_chg) begin
      meas_on_ff <= pole_s && energize;
      meas_cnt_ff <= '0;
    end else if (meas_done) begin
      meas_on_ff <= 1'b0;
      last_meas_ff <= meas_cnt_ff;
    end else if (meas_on_ff && tick_ff && meas_cnt_ff != MEAS_MAX) begin
      meas_cnt_ff <= meas_cnt_ff + 16'h0001;
    end
  end

  assign meas_done = meas_on_ff && a_low_s && !pole_chg;

  // 2 * slope / period equals slope / half period; target is 1/16
  assign meas_scaled = 24'(meas_cnt_ff) * 24'(RATIO_DIV);
  assign in_window = last_half_ff >= HALF_MIN_US
                  && last_half_ff <= HALF_MAX_US;

  // Slope code: bus load, or one saturating step per measured half
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      code_ff <= SLOPE_RST;
    end else if (wr_en && wr_hit && word_addr(aw_addr_ff) == REG_SLOPE
                 && w_strb_ff[0]) begin
      code_ff <= (w_data_ff[7:0] == 8'h00) ? SLOPE_MIN : w_data_ff[7:0];
    end else if (meas_done && adapt_en_ff && in_window) begin
      code_ff <= step_code(code_ff,
                           meas_scaled < last_half_ff,
                           meas_scaled > last_half_ff);
    end
  end

  // Applied during the south half, ahead of coil A's next rising slope
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      slope_setting <= SLOPE_RST;
    end else if (hot1_s) begin
      slope_setting <= {1'b0, code_ff[7:1]};
    end else begin
      slope_setting <= code_ff;
    end
  end

  // Coil pins; released while off or overheated
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      coil_drive_a_out <= 1'b0;
      coil_drive_b_out <= 1'b0;
      coil_drive_a_oe_n <= 1'b1;
      coil_drive_b_oe_n <= 1'b1;
    end else begin
      coil_drive_a_out <= 1'b0;
      coil_drive_b_out <= 1'b0;
      coil_drive_a_oe_n <= energize ? !pole_s : 1'b1;
      coil_drive_b_oe_n <= energize ? pole_s : 1'b1;
    end
  end

  // Speed or alarm pin
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      speed_pulse_out <= 1'b0;
      speed_pulse_oe_n <= 1'b1;
    end else begin
      speed_pulse_out <= 1'b0;
      if (!por_done_ff || hot2_s) begin
        speed_pulse_oe_n <= 1'b1;
      end else if (alarm_mode_ff) begin
        speed_pulse_oe_n <= !(state_ff == LK_RUN && !slow);
      end else if (state_ff != LK_RUN) begin
        speed_pulse_oe_n <= 1'b1;
      end else begin
        speed_pulse_oe_n <= !pole_s;
      end
    end
  end

  // Write channel: address and data taken in either order
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b0;
      s_axi_wready <= 1'b0;
      aw_full_ff <= 1'b0;
      w_full_ff <= 1'b0;
      aw_addr_ff <= 8'h00;
      w_data_ff <= 32'h0;
      w_strb_ff <= 4'h0;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= RESP_OKAY;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_full_ff <= 1'b1;
        aw_addr_ff <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end else if (!aw_full_ff && !s_axi_bvalid) begin
        s_axi_awready <= 1'b1;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_full_ff <= 1'b1;
        w_data_ff <= s_axi_wdata;
        w_strb_ff <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end else if (!w_full_ff && !s_axi_bvalid) begin
        s_axi_wready <= 1'b1;
      end
      if (wr_en) begin
        aw_full_ff <= 1'b0;
        w_full_ff <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= wr_hit ? RESP_OKAY : RESP_SLVERR;
      end else if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
      end
    end
  end

  assign wr_en = aw_full_ff && w_full_ff && !s_axi_bvalid;
  // Status and measurement words accept writes but ignore them
  assign wr_hit = word_addr(aw_addr_ff) <= REG_MEAS;

  // Control register: variant select and adaptation enable
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      alarm_mode_ff <= CTRL_ALARM_RST;
      adapt_en_ff <= CTRL_ADAPT_RST;
    end else if (wr_en && word_addr(aw_addr_ff) == REG_CTRL && w_strb_ff[0]) begin
      alarm_mode_ff <= w_data_ff[CTRL_ALARM_BIT];
      adapt_en_ff <= w_data_ff[CTRL_ADAPT_BIT];
    end
  end

  // Read mux
  always_comb begin
    rd_word = 32'h0;
    rd_hit = 1'b1;
    unique case (word_addr(s_axi_araddr))
      REG_CTRL: begin
        rd_word[CTRL_ALARM_BIT] = alarm_mode_ff;
        rd_word[CTRL_ADAPT_BIT] = adapt_en_ff;
      end
      REG_SLOPE: rd_word[7:0] = code_ff;
      REG_STATUS: begin
        rd_word[ST_POLE_BIT] = pole_s;
        rd_word[ST_HOT1_BIT] = hot1_s;
        rd_word[ST_HOT2_BIT] = hot2_s;
        rd_word[ST_SLOW_BIT] = slow;
        rd_word[ST_STATE_LSB +: 2] = state_ff;
        rd_word[ST_POR_BIT] = por_done_ff;
      end
      REG_HALF: rd_word[23:0] = last_half_ff;
      REG_MEAS: rd_word[15:0] = last_meas_ff;
      default: rd_hit = 1'b0;
    endcase
  end

  // Read channel: one read under way at a time
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0;
      s_axi_rresp <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_word;
      s_axi_rresp <= rd_hit ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end else if (!s_axi_rvalid) begin
      s_axi_arready <= 1'b1;
    end
  end

endmodule

//--- sim/fan_coil_model.sv
// Coil and speed pin model: pull-ups, coil A falls slowly when driven.
// Assumes active-low open-drain enables from the fan block.
`timescale 1ns/1ps
module fan_coil_model #(
  parameter int SLEW_CYC = 40
) (
  // Clock
  input wire logic aclk,
  // Open-drain enables
  input wire logic a_oe_n,
  input wire logic b_oe_n,
  input wire logic s_oe_n,
  // Pin levels
  output logic a_pin,
  output logic b_pin,
  output logic s_pin
);
  int slew_ff;
  // Coil A crossover only after a finite slope, never at once
  always_ff @(posedge aclk) begin
    if (a_oe_n) slew_ff <= 0;
    else if (slew_ff < SLEW_CYC) slew_ff <= slew_ff + 1;
  end
  // Released pins go to the pull-up level
  assign a_pin = a_oe_n ? 1'b1 : (slew_ff < SLEW_CYC);
  assign b_pin = b_oe_n;
  assign s_pin = s_oe_n;
endmodule

//--- sim/fan_commute_asserts.sv
// Checker for coil, speed pin and slope code relations of the fan block.
// Assumes it is bound into fan_commute_top and sees only its ports.
`timescale 1ns/1ps
module fan_commute_checker #(
  parameter logic [23:0] LOCK_US = fan_pkg::LOCK_US,
  parameter logic [23:0] RESTART_US = fan_pkg::RESTART_US,
  parameter logic [23:0] POR_US = fan_pkg::POR_US
) (
  // Clock and reset
  input wire logic aclk,
  input wire logic aresetn,
  // Comparator flags
  input wire logic pole_south_in,
  input wire logic thermal_stage1_in,
  input wire logic thermal_stage2_in,
  // Pin enables and slope code
  input wire logic coil_drive_a_oe_n,
  input wire logic coil_drive_b_oe_n,
  input wire logic speed_pulse_oe_n,
  input wire logic [fan_pkg::SLOPE_W-1:0] slope_setting
);
  import fan_pkg::*;
  // Slack covers tick phase and the synchronisers
  localparam int SLACK = 400;
  localparam int LK = int'(LOCK_US) * TICK_CYC;
  localparam int RS = int'(RESTART_US) * TICK_CYC;
  localparam int PO = int'(POR_US) * TICK_CYC - TICK_CYC;
  int rst_cnt;
  int still_cnt;
  logic pole_q;
  // Cycles since reset release
  always_ff @(posedge aclk) begin
    if (!aresetn) rst_cnt <= 0;
    else if (rst_cnt < PO) rst_cnt <= rst_cnt + 1;
  end
  // Cycles without a pole change; saturates past one retry
  always_ff @(posedge aclk) begin
    pole_q <= pole_south_in;
    if (!aresetn || pole_q != pole_south_in) still_cnt <= 0;
    else if (still_cnt < RS + LK) still_cnt <= still_cnt + 1;
  end
  coil_compl_a: assert property (@(posedge aclk) disable iff (!aresetn)
    coil_drive_a_oe_n || coil_drive_b_oe_n) else $error("both coils on");
  south_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    pole_south_in [*6] ##0 (coil_drive_a_oe_n != coil_drive_b_oe_n) |-> !coil_drive_a_oe_n)
    else $error("south not on coil a");
  north_drive_a: assert property (@(posedge aclk) disable iff (!aresetn)
    !pole_south_in [*6] ##0 (coil_drive_a_oe_n != coil_drive_b_oe_n) |-> coil_drive_a_oe_n)
    else $error("north not on coil b");
  hot_release_a: assert property (@(posedge aclk) disable iff (!aresetn)
    thermal_stage2_in [*6] |-> coil_drive_a_oe_n && coil_drive_b_oe_n && speed_pulse_oe_n)
    else $error("hot shutdown missed");
  hot_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (thermal_stage2_in && coil_drive_a_oe_n && coil_drive_b_oe_n) [*4]
    |=> coil_drive_a_oe_n && coil_drive_b_oe_n) else $error("hot shutdown left");
  slope_half_a: assert property (@(posedge aclk) disable iff (!aresetn)
    thermal_stage1_in [*6] |-> slope_setting <= 8'h7F) else $error("slope not halved");
  lock_speed_a: assert property (@(posedge aclk) disable iff (!aresetn)
    (coil_drive_a_oe_n && coil_drive_b_oe_n) [*6] |-> speed_pulse_oe_n)
    else $error("speed pin low while off");
  por_hold_a: assert property (@(posedge aclk) disable iff (!aresetn)
    rst_cnt < PO |-> speed_pulse_oe_n) else $error("speed pin early");
  lock_off_a: assert property (@(posedge aclk) disable iff (!aresetn)
    still_cnt >= LK + SLACK && still_cnt <= RS - SLACK
    |-> coil_drive_a_oe_n && coil_drive_b_oe_n) else $error("blocked rotor driven");
  retry_on_a: assert property (@(posedge aclk) disable iff (!aresetn)
    still_cnt >= RS + SLACK && still_cnt <= RS + LK - SLACK && !thermal_stage2_in
    |-> coil_drive_a_oe_n != coil_drive_b_oe_n) else $error("no restart");
endmodule
bind fan_commute_top fan_commute_checker #(
  .LOCK_US(LOCK_US), .RESTART_US(RESTART_US), .POR_US(POR_US)
) chk (
  .aclk(aclk), .aresetn(aresetn), .pole_south_in(pole_south_in),
  .thermal_stage1_in(thermal_stage1_in), .thermal_stage2_in(thermal_stage2_in),
  .coil_drive_a_oe_n(coil_drive_a_oe_n), .coil_drive_b_oe_n(coil_drive_b_oe_n),
  .speed_pulse_oe_n(speed_pulse_oe_n), .slope_setting(slope_setting)
);

//--- sim/tb_top.sv
// Self-checking bench for the fan commutation block.
// Assumes the coil model and the bound checker are compiled alongside.
`timescale 1ns/1ps
module tb_top;
  import fan_pkg::*;
  logic aclk, aresetn, pole_south_in, thermal_stage1_in, thermal_stage2_in;
  logic coil_drive_a_in, coil_drive_b_in, speed_pulse_in;
  logic coil_drive_a_oe_n, coil_drive_b_oe_n, speed_pulse_oe_n;
  logic [SLOPE_W-1:0] slope_setting;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, lfsr;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic s_axi_rvalid, s_axi_rready;
  logic [3:0] s_axi_wstrb;
  logic coil_drive_a_out, coil_drive_b_out, speed_pulse_out;
  logic [7:0] v;
  logic [33:0] rq[$];
  logic [1:0] bq[$];
  int bad_count, checks_done;
  // 100 MHz clock
  initial begin
    aclk = 1'b0;
    forever #5 aclk = ~aclk;
  end
  // Short times; alarm threshold kept under the lock time so both show
  fan_commute_top #(
    .LOCK_US(24'h14), .RESTART_US(24'h3C), .POR_US(24'h5), .ALARM_US(24'hA)
  ) DUT (
    .aclk, .aresetn, .pole_south_in, .thermal_stage1_in, .thermal_stage2_in,
    .coil_drive_a_in, .coil_drive_a_out, .coil_drive_a_oe_n,
    .coil_drive_b_in, .coil_drive_b_out, .coil_drive_b_oe_n,
    .speed_pulse_in, .speed_pulse_out, .speed_pulse_oe_n, .slope_setting,
    .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arprot(3'h0), .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready
  );
  fan_coil_model coils (
    .aclk(aclk), .a_oe_n(coil_drive_a_oe_n), .b_oe_n(coil_drive_b_oe_n),
    .s_oe_n(speed_pulse_oe_n), .a_pin(coil_drive_a_in), .b_pin(coil_drive_b_in),
    .s_pin(speed_pulse_in)
  );
  function automatic logic [31:0] lfsr_next(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction
  task automatic check(input string name, input logic [33:0] seen, input logic [33:0] exp);
    checks_done++;
    if (seen !== exp) begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge aclk);
  endtask
  // Pins are looked at mid-cycle, then back on the rising edge
  task automatic pins(input logic ea, input logic eb, input logic es);
    @(negedge aclk);
    check("coil_a_oe_n", 34'(coil_drive_a_oe_n), 34'(ea));
    check("coil_b_oe_n", 34'(coil_drive_b_oe_n), 34'(eb));
    check("speed_oe_n", 34'(speed_pulse_oe_n), 34'(es));
    check("pin_out", 34'({coil_drive_a_out, coil_drive_b_out, speed_pulse_out}), 34'(0));
    @(posedge aclk);
  endtask
  task automatic slope_is(input logic [7:0] e);
    @(negedge aclk);
    check("slope_setting", 34'(slope_setting), 34'(e));
    @(posedge aclk);
  endtask
  // Write: address and data offered together, each dropped when taken
  task automatic axi_wr(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    bit aw_t;
    bit w_t;
    bq.push_back(er);
    aw_t = 1'b0;
    w_t = 1'b0;
    s_axi_awaddr <= ad;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    while (!(aw_t && w_t)) begin
      @(posedge aclk);
      if (s_axi_awvalid && s_axi_awready) begin
        aw_t = 1'b1;
        s_axi_awvalid <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_t = 1'b1;
        s_axi_wvalid <= 1'b0;
      end
    end
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (s_axi_bvalid !== 1'b1);
    s_axi_bready <= 1'b0;
  endtask
  task automatic axi_rd(input logic [7:0] ad, input logic [31:0] d, input logic [1:0] er);
    rq.push_back({er, d});
    s_axi_araddr <= ad;
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (s_axi_arready !== 1'b1);
    s_axi_arvalid <= 1'b0;
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (s_axi_rvalid !== 1'b1);
    s_axi_rready <= 1'b0;
  endtask
  // Random half periods, short of both the alarm and the lock times
  task automatic spin(input int n, input logic alarm);
    repeat (n) begin
      pole_south_in <= ~pole_south_in;
      lfsr = lfsr_next(lfsr);
      cyc(300 + int'(lfsr[8:0]));
      pins(!pole_south_in, pole_south_in, !alarm && !pole_south_in); // Follow pole
    end
  endtask
  task automatic summarize;
    $display("checks %0d mismatches %0d", checks_done, bad_count);
    if (bad_count == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  // Bus answers against the oldest note
  always @(posedge aclk) begin
    if (s_axi_rvalid && s_axi_rready && rq.size() > 0)
      check("rdata", {s_axi_rresp, s_axi_rdata}, rq.pop_front());
    if (s_axi_bvalid && s_axi_bready && bq.size() > 0)
      check("bresp", 34'(s_axi_bresp), 34'(bq.pop_front()));
  end
  // Main sequence
  initial begin
    {aresetn, thermal_stage1_in, thermal_stage2_in} = 3'h0;
    {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h0;
    {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 48'h0;
    pole_south_in = 1'b1;
    lfsr = 32'h7E60;
    s_axi_wstrb = 4'hF;
    bad_count = 0;
    checks_done = 0;
    cyc(3);
    aresetn <= 1'b1;
    cyc(100);
    pins(1'b0, 1'b1, 1'b1); // Speed pin held after reset
    axi_rd(REG_CTRL, 32'h2, RESP_OKAY);
    axi_rd(REG_SLOPE, 32'h20, RESP_OKAY);
    axi_rd(8'h20, 32'h0, RESP_SLVERR);
    axi_wr(8'h20, 32'hFFFFFFFF, RESP_SLVERR);
    spin(6, 1'b0);
    lfsr = lfsr_next(lfsr);
    v = lfsr[7:0] | 8'h01;
    axi_wr(REG_SLOPE, {24'h0, v}, RESP_OKAY);
    slope_is(v); // Code in use
    thermal_stage1_in <= 1'b1;
    cyc(8);
    slope_is(v >> 1); // Halved when hot
    thermal_stage1_in <= 1'b0;
    cyc(8);
    slope_is(v); // Full again
    axi_wr(REG_SLOPE, 32'h0, RESP_OKAY);
    axi_rd(REG_SLOPE, 32'h1, RESP_OKAY); // Floor of the code
    s_axi_wstrb <= 4'h0;
    axi_wr(REG_SLOPE, 32'h55, RESP_OKAY);
    axi_rd(REG_SLOPE, 32'h1, RESP_OKAY); // Strobe off keeps the code
    s_axi_wstrb <= 4'hF;
    spin(2, 1'b0);
    thermal_stage2_in <= 1'b1;
    cyc(8);
    pins(1'b1, 1'b1, 1'b1); // All released
    pole_south_in <= ~pole_south_in;
    cyc(20);
    pins(1'b1, 1'b1, 1'b1); // Still released with pole moving
    thermal_stage2_in <= 1'b0;
    cyc(8);
    pins(!pole_south_in, pole_south_in, !pole_south_in); // Running again
    axi_wr(REG_CTRL, 32'h3, RESP_OKAY);
    spin(4, 1'b1);
    pole_south_in <= ~pole_south_in;
    cyc(1400);
    pins(!pole_south_in, pole_south_in, 1'b1); // Slow rotation raises alarm
    axi_wr(REG_CTRL, 32'h2, RESP_OKAY);
    cyc(1200);
    pins(1'b1, 1'b1, 1'b1); // Blocked rotor, speed pin high
    axi_rd(REG_STATUS, 32'h59, RESP_OKAY); // South, slow, off, hold done
    cyc(4100);
    pins(!pole_south_in, pole_south_in, 1'b1); // Restart attempt
    cyc(2000);
    pins(1'b1, 1'b1, 1'b1); // Off again after attempt
    spin(2, 1'b0);
    summarize();
  end
  // Watchdog, well past the expected run length
  initial begin
    #600000;
    bad_count++;
    summarize();
  end
endmodule
